// ==== logic/dpr_ctl_end.sv ====
// power, clock and reset controller end of the debug handshake
`timescale 1ns/1ps
module dpr_ctl_end (
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // configuration straps
  input  wire logic                  tie_off_mode,
  input  wire logic                  single_domain,
  input  wire logic                  reset_block,
  // power rails
  input  wire logic [1:0]            rail_good,
  output logic      [1:0]            rail_en,
  output logic      [1:0]            domain_clk_en,
  // other requesters
  input  wire logic [1:0]            keep_power,
  input  wire logic [1:0]            other_lowpower_req,
  output logic      [1:0]            other_lowpower_ack,
  output logic      [1:0]            lowpower_emulated,
  // debug domain reset
  output logic                       dbg_reset_n,
  // link
  dpr_link_if.ctl_end                link
);
  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [dpr_pkg::NUM_HS-1:0]   s1;
    logic [dpr_pkg::NUM_HS-1:0]   s2;
    dpr_pkg::dpr_pwr_e [1:0]      pst;
    logic [1:0]                   lp_ack;
    dpr_pkg::dpr_rst_e            rst;
    logic                         rst_hit;
    logic [dpr_pkg::CNT_W-1:0]    cnt;
    logic [1:0]                   clk_en;
    logic [1:0]                   lp_emu;
    logic                         rst_n;
  } dpr_ctl_s;

  dpr_ctl_s q_r;
  dpr_ctl_s q_nxt;

  logic [dpr_pkg::NUM_HS-1:0] req_raw;
  logic [1:0]                 good;
  logic [1:0]                 hold;
  logic [1:0]                 fsm_ack;
  logic                       dbg_powered;

  //----------------------------------------------------------------------------
  // link inputs
  //----------------------------------------------------------------------------
  // requests come from another domain: the state machines decode only the second flop stage
  assign req_raw = {link.dbg_domain_reset_request, link.sys_domain_power_request,
                    link.dbg_domain_power_request};

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  function automatic logic is_on(input dpr_pkg::dpr_pwr_e s);
    is_on = (s == dpr_pkg::PW_ON);
  endfunction : is_on

  function automatic logic is_held(input dpr_pkg::dpr_pwr_e s);
    is_held = (s == dpr_pkg::PW_UP) || (s == dpr_pkg::PW_ON);
  endfunction : is_held

  // shared-rail builds power the debug logic from the system domain
  function automatic logic dbg_is_up(input dpr_pkg::dpr_pwr_e [1:0] p, input logic shared);
    dbg_is_up = is_on(p[dpr_pkg::DOM_DBG]) || (shared && is_on(p[dpr_pkg::DOM_SYS]));
  endfunction : dbg_is_up

  //----------------------------------------------------------------------------
  // rail and domain decode
  //----------------------------------------------------------------------------
  always_comb begin
    // with one shared rail the debug side waits on the system rail
    good[dpr_pkg::DOM_SYS] = rail_good[dpr_pkg::DOM_SYS];
    good[dpr_pkg::DOM_DBG] = single_domain ? rail_good[dpr_pkg::DOM_SYS]
                                           : rail_good[dpr_pkg::DOM_DBG];
    for (int i = 0; i < dpr_pkg::NUM_DOM; i++) begin
      hold[i]    = is_held(q_r.pst[i]);
      fsm_ack[i] = is_on(q_r.pst[i]);
    end
    // a held rail ignores other low-power requests; otherwise they win over keep
    rail_en[dpr_pkg::DOM_DBG] = !single_domain &&
      (hold[dpr_pkg::DOM_DBG] ||
       (keep_power[dpr_pkg::DOM_DBG] && !other_lowpower_req[dpr_pkg::DOM_DBG]));
    rail_en[dpr_pkg::DOM_SYS] = hold[dpr_pkg::DOM_SYS] ||
      (single_domain && hold[dpr_pkg::DOM_DBG]) ||
      (keep_power[dpr_pkg::DOM_SYS] && !other_lowpower_req[dpr_pkg::DOM_SYS]);
    dbg_powered   = dbg_is_up(q_r.pst, single_domain);
  end

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = req_raw;
    q_nxt.s2 = q_r.s1;
    // power handshake, one machine per domain
    for (int i = 0; i < dpr_pkg::NUM_DOM; i++) begin
      case (q_r.pst[i])
        dpr_pkg::PW_OFF: begin
          if (q_r.s2[i]) begin
            q_nxt.pst[i] = dpr_pkg::PW_UP;
          end
        end
        dpr_pkg::PW_UP: begin
          // an already-good rail passes straight through; a withdrawn request
          // goes back to off so the ack never rises unasked
          if (!q_r.s2[i]) begin
            q_nxt.pst[i] = dpr_pkg::PW_OFF;
          end else if (good[i]) begin
            q_nxt.pst[i] = dpr_pkg::PW_ON;
          end
        end
        dpr_pkg::PW_ON: begin
          if (!q_r.s2[i]) begin
            q_nxt.pst[i] = dpr_pkg::PW_DOWN;
          end
        end
        dpr_pkg::PW_DOWN: begin
          // ack already low here; a new request must wait for it to be seen low
          q_nxt.pst[i] = dpr_pkg::PW_OFF;
        end
        default: begin
          q_nxt.pst[i] = dpr_pkg::PW_OFF;
        end
      endcase
    end
    // other requesters always get their handshake completed
    q_nxt.lp_ack = other_lowpower_req;
    // debug reset handshake
    case (q_r.rst)
      dpr_pkg::RS_IDLE: begin
        if (q_r.s2[dpr_pkg::HS_RST]) begin
          if (reset_block) begin
            q_nxt.rst = dpr_pkg::RS_REFUSE;
          end else begin
            q_nxt.rst     = dpr_pkg::RS_PULSE;
            q_nxt.cnt     = dpr_pkg::CNT_LOAD;
            q_nxt.rst_hit = dbg_powered;
          end
        end
      end
      dpr_pkg::RS_PULSE: begin
        if (q_r.cnt == dpr_pkg::CNT_ZERO) begin
          q_nxt.rst = dpr_pkg::RS_ACK;
        end else begin
          q_nxt.cnt = q_r.cnt - 1'b1;
        end
      end
      dpr_pkg::RS_ACK: begin
        if (!q_r.s2[dpr_pkg::HS_RST]) begin
          q_nxt.rst = dpr_pkg::RS_IDLE;
        end
      end
      dpr_pkg::RS_REFUSE: begin
        // a blocked reset keeps the ack low until the request is withdrawn
        if (!q_r.s2[dpr_pkg::HS_RST]) begin
          q_nxt.rst = dpr_pkg::RS_IDLE;
        end
      end
      default: begin
        q_nxt.rst = dpr_pkg::RS_IDLE;
      end
    endcase
    // reset, clock gate and emulation flag come from flops:
    // a decode of the state would glitch them
    q_nxt.rst_n = dbg_is_up(q_nxt.pst, single_domain) &&
                  !(q_nxt.rst == dpr_pkg::RS_PULSE && q_nxt.rst_hit);
    for (int i = 0; i < dpr_pkg::NUM_DOM; i++) begin
      q_nxt.clk_en[i] = is_on(q_nxt.pst[i]);
      q_nxt.lp_emu[i] = q_nxt.lp_ack[i] && is_held(q_nxt.pst[i]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  assign other_lowpower_ack = q_r.lp_ack;
  assign lowpower_emulated  = q_r.lp_emu;
  // clocks only run once the domain is acknowledged as up
  assign domain_clk_en      = q_r.clk_en;
  // access port held in reset while its domain is down, and during the pulse
  assign dbg_reset_n        = q_r.rst_n;
  // combinational loop-back keeps the tie-off ack immediate on both edges
  assign link.dbg_domain_power_ack = tie_off_mode ? link.dbg_domain_power_request
                                                  : fsm_ack[dpr_pkg::DOM_DBG];
  assign link.sys_domain_power_ack = (tie_off_mode || single_domain)
                                   ? link.sys_domain_power_request
                                   : fsm_ack[dpr_pkg::DOM_SYS];
  // ack stays low in tie-off mode so a debugger can time out
  assign link.dbg_domain_reset_ack = !tie_off_mode &&
                                     (q_r.rst == dpr_pkg::RS_ACK);
endmodule : dpr_ctl_end

// ==== common/dpr_pkg.sv ====
// constants, state types and register layout for the debug power/reset handshake
//------------------------------------------------------------------------------
// Summary of operation
// - system power and clocks up, then acknowledge
// - system acknowledge stays high while request high
// - system request only with debug request set
// - emulate system-domain power-down for non-debug logic
// - acknowledge even when domain already powered
// - access-port transfers only when debug request+ack
// - lowering request asks power removal; ack follows
// - acknowledges low from reset, rise on request
// - graceful power-down unless others need power
// - re-request only after acknowledge reads low
// - conflicting power-down completes but power stays
// - no handshake scheme: ack tied to request
// - single domain: looped system ack, generated debug
// - reset request bit 26, acknowledge bit 27
// - debug reset hits access port, not debug port
// - reset done raises reset acknowledge
// - debugger polls ack, then clears reset request
// - request falls, reset acknowledge falls
// - reset request held until acknowledge rises
// - reset ignored for powered-down components
// - always-on request bits writable any time
// - power request/ack bits 28 to 31
//------------------------------------------------------------------------------
package dpr_pkg;
  // register map
  localparam logic [31:0] ADDR_CTRL_STAT = 32'h0000_0000;
  localparam int          ADDR_LSB       = 2;
  localparam int          BIT_RST_REQ    = 26;
  localparam int          BIT_RST_ACK    = 27;
  localparam int          BIT_DBG_REQ    = 28;
  localparam int          BIT_DBG_ACK    = 29;
  localparam int          BIT_SYS_REQ    = 30;
  localparam int          BIT_SYS_ACK    = 31;
  localparam logic [31:0] CTRL_STAT_RST  = 32'h0000_0000;
  // ahb encodings
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]  HRESP_OKAY     = 2'h0;
  // domain and handshake indices
  localparam int          DOM_DBG        = 0;
  localparam int          DOM_SYS        = 1;
  localparam int          HS_RST         = 2;
  localparam int          NUM_DOM        = 2;
  localparam int          NUM_HS         = 3;
  // debug reset pulse width
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          RST_PULSE_NS   = 100;
  localparam int          RST_CYC        = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W          = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
  localparam logic [CNT_W-1:0] CNT_LOAD  = 4'(RST_CYC - 1);

  typedef enum logic [1:0] {
    PW_OFF,
    PW_UP,
    PW_ON,
    PW_DOWN
  } dpr_pwr_e;

  typedef enum logic [1:0] {
    RS_IDLE,
    RS_PULSE,
    RS_ACK,
    RS_REFUSE
  } dpr_rst_e;
endpackage : dpr_pkg

// ==== common/dpr_link_if.sv ====
// request/acknowledge wires between the debug port and the power/reset controller
`timescale 1ns/1ps
interface dpr_link_if;
  logic sys_domain_power_request;
  logic sys_domain_power_ack;
  logic dbg_domain_power_request;
  logic dbg_domain_power_ack;
  logic dbg_domain_reset_request;
  logic dbg_domain_reset_ack;

  modport port_end (
    output sys_domain_power_request,
    output dbg_domain_power_request,
    output dbg_domain_reset_request,
    input  sys_domain_power_ack,
    input  dbg_domain_power_ack,
    input  dbg_domain_reset_ack
  );

  modport ctl_end (
    input  sys_domain_power_request,
    input  dbg_domain_power_request,
    input  dbg_domain_reset_request,
    output sys_domain_power_ack,
    output dbg_domain_power_ack,
    output dbg_domain_reset_ack
  );
endinterface : dpr_link_if

// ==== logic/dpr_port_end.sv ====
// debug port end: always-on control/status register on ahb-lite, drives the requests
`timescale 1ns/1ps
module dpr_port_end (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [1:0]       hresp,
  output logic [31:0]      hrdata,
  // user side
  output logic             ap_access_ok,
  // link
  dpr_link_if.port_end     link
);
  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [dpr_pkg::NUM_HS-1:0] req;
    logic [dpr_pkg::NUM_HS-1:0] ack_s1;
    logic [dpr_pkg::NUM_HS-1:0] ack_s2;
    logic                       wr_pend;
    logic [31:0]                rdata;
  } dpr_port_s;

  dpr_port_s q_r;
  dpr_port_s q_nxt;

  logic [dpr_pkg::NUM_HS-1:0] ack_in;
  logic                       hit;
  logic                       acc;
  logic [31:0]                stat;

  // ack order matches req order: dbg, sys, rst
  assign ack_in = {link.dbg_domain_reset_ack, link.sys_domain_power_ack,
                   link.dbg_domain_power_ack};
  assign acc    = hsel && hready && htrans == dpr_pkg::HTRANS_NONSEQ;
  assign hit    = acc &&
                  haddr[31:dpr_pkg::ADDR_LSB] == dpr_pkg::ADDR_CTRL_STAT[31:dpr_pkg::ADDR_LSB];

  //----------------------------------------------------------------------------
  // status image
  //----------------------------------------------------------------------------
  always_comb begin
    stat                           = dpr_pkg::CTRL_STAT_RST;
    stat[dpr_pkg::BIT_RST_REQ]     = q_r.req[dpr_pkg::HS_RST];
    stat[dpr_pkg::BIT_RST_ACK]     = q_r.ack_s2[dpr_pkg::HS_RST];
    stat[dpr_pkg::BIT_DBG_REQ]     = q_r.req[dpr_pkg::DOM_DBG];
    stat[dpr_pkg::BIT_DBG_ACK]     = q_r.ack_s2[dpr_pkg::DOM_DBG];
    stat[dpr_pkg::BIT_SYS_REQ]     = q_r.req[dpr_pkg::DOM_SYS];
    stat[dpr_pkg::BIT_SYS_ACK]     = q_r.ack_s2[dpr_pkg::DOM_SYS];
  end

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb begin
    q_nxt        = q_r;
    // first stage feeds only the second
    q_nxt.ack_s1 = ack_in;
    q_nxt.ack_s2 = q_r.ack_s1;
    q_nxt.wr_pend = hit && hwrite;
    // any other address reads zero, never a stale status image
    if (acc && !hwrite) begin
      q_nxt.rdata = hit ? stat : '0;
    end
    // no gating on power state: the request bits sit in the always-on domain
    if (q_r.wr_pend) begin
      q_nxt.req[dpr_pkg::HS_RST]  = hwdata[dpr_pkg::BIT_RST_REQ];
      q_nxt.req[dpr_pkg::DOM_DBG] = hwdata[dpr_pkg::BIT_DBG_REQ];
      q_nxt.req[dpr_pkg::DOM_SYS] = hwdata[dpr_pkg::BIT_SYS_REQ];
    end
  end

  // only hresetn clears this state; a debug reset never reaches it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = dpr_pkg::HRESP_OKAY;
  assign hrdata    = q_r.rdata;
  assign link.dbg_domain_power_request = q_r.req[dpr_pkg::DOM_DBG];
  assign link.sys_domain_power_request = q_r.req[dpr_pkg::DOM_SYS];
  assign link.dbg_domain_reset_request = q_r.req[dpr_pkg::HS_RST];
  assign ap_access_ok = q_r.req[dpr_pkg::DOM_DBG] && q_r.ack_s2[dpr_pkg::DOM_DBG];
endmodule : dpr_port_end

// ==== sim/dpr_link_chk.sv ====
// concurrent checks on the request/acknowledge link
`timescale 1ns/1ps
module dpr_link_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  input wire logic sys_domain_power_request,
  input wire logic sys_domain_power_ack,
  input wire logic dbg_domain_power_request,
  input wire logic dbg_domain_power_ack,
  input wire logic dbg_domain_reset_request,
  input wire logic dbg_domain_reset_ack
);
  //----------------------------------------------------------------------------
  // properties
  //----------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // acknowledged reset, then the request is withdrawn
  sequence s_rst_done;
    dbg_domain_reset_request && dbg_domain_reset_ack;
  endsequence
  sequence s_rst_drop;
    s_rst_done ##1 !dbg_domain_reset_request;
  endsequence

  a_dbg_ack_cause: assert property (
    $rose(dbg_domain_power_ack) |-> dbg_domain_power_request) else $error("dbg ack unasked");
  a_sys_ack_cause: assert property (
    $rose(sys_domain_power_ack) |-> sys_domain_power_request) else $error("sys ack unasked");
  a_dbg_ack_hold: assert property (
    $fell(dbg_domain_power_ack) |-> !dbg_domain_power_request) else $error("dbg ack dropped");
  a_sys_ack_hold: assert property (
    $fell(sys_domain_power_ack) |-> !sys_domain_power_request) else $error("sys ack dropped");
  // bound covers sync, rail ramp and the single-domain wait
  a_dbg_ack_rise: assert property (
    $rose(dbg_domain_power_request) |-> ##[0:40] dbg_domain_power_ack) else $error("dbg no ack");
  a_sys_ack_rise: assert property (
    $rose(sys_domain_power_request) |-> ##[0:40] sys_domain_power_ack) else $error("sys no ack");
  a_dbg_ack_drop: assert property (
    $fell(dbg_domain_power_request) |-> ##[0:8] !dbg_domain_power_ack) else $error("dbg ack stuck");
  a_sys_ack_drop: assert property (
    $fell(sys_domain_power_request) |-> ##[0:8] !sys_domain_power_ack) else $error("sys ack stuck");
  a_rst_ack_cause: assert property (
    $rose(dbg_domain_reset_ack) |-> dbg_domain_reset_request) else $error("rst ack unasked");
  a_rst_ack_fall: assert property (
    s_rst_drop |-> ##[0:8] !dbg_domain_reset_ack) else $error("rst ack stuck");
  a_rst_ack_hold: assert property (
    $fell(dbg_domain_reset_ack) |-> !dbg_domain_reset_request) else $error("rst ack dropped");
endmodule : dpr_link_chk

// ==== sim/dpr_bench.sv ====
// self-checking bench: both handshake ends joined, driven over ahb-lite
`timescale 1ns/1ps
module dpr_bench;
  //----------------------------------------------------------------------------
  // signals
  //----------------------------------------------------------------------------
  localparam logic [31:0] RQ = 32'h0400_0000;
  localparam logic [31:0] RA = 32'h0800_0000;
  localparam logic [31:0] DQ = 32'h1000_0000;
  localparam logic [31:0] DA = 32'h2000_0000;
  localparam logic [31:0] SQ = 32'h4000_0000;
  localparam logic [31:0] SA = 32'h8000_0000;
  localparam logic [31:0] CS = dpr_pkg::ADDR_CTRL_STAT;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        tie_off_mode = 1'b0;
  logic        single_domain = 1'b0;
  logic        reset_block = 1'b0;
  int          rst_cyc = 0;
  int          rst_base = 0;
  logic [1:0]  rail_good = 2'h0;
  logic [1:0]  keep_power = 2'h0;
  logic [1:0]  other_lowpower_req = 2'h0;
  logic        hreadyout;
  logic        ap_access_ok;
  logic        dbg_reset_n;
  logic [1:0]  hresp;
  logic [1:0]  rail_en;
  logic [1:0]  domain_clk_en;
  logic [1:0]  lowpower_emulated;
  logic [1:0]  other_lowpower_ack;
  logic [31:0] hrdata;
  logic [31:0] r;
  int          bad_count = 0;
  int          compares = 0;

  dpr_link_if link_inst ();
  always #10 hclk = ~hclk;
  // rails come good one cycle after enable
  always @(posedge hclk) rail_good <= rail_en;
  // counts cycles of the debug reset pulse while the debug domain runs
  always @(posedge hclk)
    if (dbg_reset_n === 1'b0 && domain_clk_en[0] === 1'b1) rst_cyc <= rst_cyc + 1;

  dpr_port_end dpr_port_end_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ap_access_ok(ap_access_ok),
    .link(link_inst));
  dpr_ctl_end dpr_ctl_end_inst (.hclk(hclk), .hresetn(hresetn), .tie_off_mode(tie_off_mode),
    .single_domain(single_domain), .reset_block(reset_block), .rail_good(rail_good),
    .rail_en(rail_en), .domain_clk_en(domain_clk_en), .keep_power(keep_power),
    .other_lowpower_req(other_lowpower_req), .other_lowpower_ack(other_lowpower_ack),
    .lowpower_emulated(lowpower_emulated), .dbg_reset_n(dbg_reset_n), .link(link_inst));
  dpr_link_chk dpr_link_chk_inst (.hclk(hclk), .hresetn(hresetn),
    .sys_domain_power_request(link_inst.sys_domain_power_request),
    .sys_domain_power_ack(link_inst.sys_domain_power_ack),
    .dbg_domain_power_request(link_inst.dbg_domain_power_request),
    .dbg_domain_power_ack(link_inst.dbg_domain_power_ack),
    .dbg_domain_reset_request(link_inst.dbg_domain_reset_request),
    .dbg_domain_reset_ack(link_inst.dbg_domain_reset_ack));

  //----------------------------------------------------------------------------
  // tasks
  //----------------------------------------------------------------------------
  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // waits for hready at an edge, then lets that edge settle
  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    #1;
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        bad_count++;
        end_of_test();
      end
      @(posedge hclk);
      #1;
    end
  endtask : rdy

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= dpr_pkg::HTRANS_NONSEQ;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask : ahb

  // write the register, then poll until the masked status matches
  task automatic go(input logic [31:0] wv, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    ahb(1'b1, CS, wv);
    ahb(1'b0, CS, 32'h0000_0000);
    while ((r & m) !== e && n < 60) begin
      n++;
      ahb(1'b0, CS, 32'h0000_0000);
    end
    chk(r & m, e);
  endtask : go

  //----------------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    ahb(1'b0, CS, 32'h0000_0000);
    chk(r, dpr_pkg::CTRL_STAT_RST);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    chk(32'(hresp), 32'(dpr_pkg::HRESP_OKAY));
    go(DQ, DQ | DA, DQ | DA);
    chk(32'(ap_access_ok), 32'h0000_0001);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    go(DQ | SQ, SQ | SA, SQ | SA);
    chk(32'(domain_clk_en), 32'h0000_0003);
    other_lowpower_req <= 2'h3;
    repeat (6) @(posedge hclk);
    chk(32'(lowpower_emulated), 32'h0000_0003);
    chk(32'(rail_en), 32'h0000_0003);
    chk(32'(other_lowpower_ack), 32'h0000_0003);
    other_lowpower_req <= 2'h0;
    rst_base = rst_cyc;
    go(DQ | SQ | RQ, RA, RA);
    chk(32'(rst_cyc - rst_base), 32'(dpr_pkg::RST_CYC));
    chk(32'(other_lowpower_ack | lowpower_emulated), 32'h0000_0000);
    go(DQ | SQ, RA | DQ | SQ, DQ | SQ);
    keep_power <= 2'h2;
    go(32'h0000_0000, DA | SA, 32'h0000_0000);
    repeat (6) @(posedge hclk);
    chk(32'(rail_en), 32'h0000_0002);
    keep_power <= 2'h0;
    go(RQ, RA, RA);
    go(32'h0000_0000, RA, 32'h0000_0000);
    reset_block <= 1'b1;
    ahb(1'b1, CS, RQ);
    repeat (20) @(posedge hclk);
    #1;
    ahb(1'b0, CS, 32'h0000_0000);
    chk(r & RA, 32'h0000_0000);
    go(32'h0000_0000, RA, 32'h0000_0000);
    reset_block <= 1'b0;
    tie_off_mode <= 1'b1;
    go(DQ | SQ | RQ, DA | SA | RA, DA | SA);
    go(32'h0000_0000, DA | SA, 32'h0000_0000);
    tie_off_mode <= 1'b0;
    single_domain <= 1'b1;
    go(DQ, DA | SA, DA);
    go(DQ | SQ, DA | SA, DA | SA);
    go(32'h0000_0000, DA | SA, 32'h0000_0000);
    end_of_test();
  end
endmodule : dpr_bench
